//--- inc/orient_map.vh
`ifndef ORIENT_MAP_VH
`define ORIENT_MAP_VH

// register indices on the 4-bit register port
`define REG_VERT_INPLANE_THRESH 4'h0
`define REG_HORIZ_INPLANE_THRESH 4'h1
`define REG_VERT_NORMAL_THRESH 4'h2
`define REG_HORIZ_NORMAL_THRESH 4'h3
`define REG_CTRL 4'h4
`define REG_ORIENT_STATUS 4'h5
`define REG_IRQ_STATUS 4'h6
`define REG_IRQ_MASK 4'h7

// field positions
`define CTRL_ORIENT_IRQ_ENABLE 0
`define IRQ_ORIENT_CHANGE 0

// reset values
`define RST_INPLANE_THRESH 8'h00
`define RST_NORMAL_THRESH 8'h00
`define RST_CTRL 8'h00
`define RST_IRQ_MASK 8'h00

// sample format: 14-bit two's complement, 4096 counts per g
`define SAMPLE_W 14
`define MAG_W 15
// in-plane level: 0.72 g at code 0x00, falling 7 counts per code step
`define INPLANE_BASE 15'h0B85
`define INPLANE_STEP 4'h7
// normal level: 0.80 g at signed code 0x00, 12 counts per code step
`define NORMAL_BASE 15'h0CCD
`define NORMAL_STEP 5'h0C

// orientation codes
`define ORIENT_UNKNOWN 3'h0
`define ORIENT_LEFT 3'h1
`define ORIENT_RIGHT 3'h2
`define ORIENT_DOWN 3'h5
`define ORIENT_UP 3'h6

`endif

//--- core/orient_axis_decide.v
`timescale 1ns/100ps
`default_nettype none
`include "orient_map.vh"

module orient_axis_decide
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // sample
    input wire i_valid,
    input wire signed [`SAMPLE_W-1:0] i_axis,
    input wire signed [`SAMPLE_W-1:0] i_z,
    // thresholds
    input wire [7:0] i_inplane_code,
    input wire [7:0] i_normal_code,
    // decisions
    output reg o_valid,
    output reg o_pos,
    output reg o_neg
);

    function [`MAG_W-1:0] mag;
        input signed [`SAMPLE_W-1:0] v;
        begin
            mag = v[`SAMPLE_W-1] ? (`MAG_W'h0 - {v[`SAMPLE_W-1], v}) : {1'b0, v};
        end
    endfunction

    wire [`MAG_W-1:0] axis_mag;
    wire [`MAG_W-1:0] z_mag;
    wire [`MAG_W-1:0] inplane_level;
    wire [`MAG_W-1:0] normal_level;
    wire signed [`MAG_W+5:0] normal_ofs;
    wire [`MAG_W+5:0] normal_sum;
    wire gate;

    assign axis_mag = mag(i_axis);
    assign z_mag = mag(i_z);
    // larger code lowers the in-plane level: wider trip angle, narrower deadband
    assign inplane_level = `INPLANE_BASE - i_inplane_code * `INPLANE_STEP;
    // signed normal code: 0x80 lowest, 0x00 default, 0x7F highest
    assign normal_ofs = $signed(i_normal_code) * $signed({1'b0, `NORMAL_STEP});
    assign normal_sum = {6'h00, `NORMAL_BASE} + normal_ofs;
    assign normal_level = normal_sum[`MAG_W-1:0];
    assign gate = (z_mag < normal_level) && (axis_mag > inplane_level);

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_pos <= 1'b0;
            o_neg <= 1'b0;
        end
        else
        begin
            o_valid <= i_valid;
            if (i_valid)
            begin
                o_pos <= gate && !i_axis[`SAMPLE_W-1];
                o_neg <= gate && i_axis[`SAMPLE_W-1];
            end
        end
    end

endmodule
`default_nettype wire

//--- core/orient_irq_unit.v
`timescale 1ns/100ps
`default_nettype none

module orient_irq_unit
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // event and software access
    input wire i_event,
    input wire i_clear,
    input wire i_mask_wr,
    input wire i_mask_val,
    // state
    output reg o_status,
    output reg o_mask,
    output reg o_irq
);

    wire status_nxt;
    wire mask_nxt;

    // a new event beats a simultaneous clear
    assign status_nxt = i_event | (o_status & ~i_clear);
    assign mask_nxt = i_mask_wr ? i_mask_val : o_mask;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_status <= 1'b0;
            o_mask <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_status <= status_nxt;
            o_mask <= mask_nxt;
            o_irq <= status_nxt & mask_nxt;
        end
    end

endmodule
`default_nettype wire

//--- core/portrait_landscape_detector.v
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "orient_map.vh"

module portrait_landscape_detector
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // sample datapath
    input wire i_sample_valid,
    input wire signed [`SAMPLE_W-1:0] i_x,
    input wire signed [`SAMPLE_W-1:0] i_y,
    input wire signed [`SAMPLE_W-1:0] i_z,
    // register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // result
    output reg [2:0] o_orient_code,
    output reg o_orient_update,
    output reg o_irq
);

    // one-hot sequencing states
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_EVAL = 3'b010;
    localparam [2:0] S_COMMIT = 3'b100;

    function hit;
        input [3:0] addr;
        input [3:0] reg_idx;
        begin
            hit = (addr == reg_idx);
        end
    endfunction

    // software registers
    reg [7:0] vert_inplane_thresh_r;
    reg [7:0] horiz_inplane_thresh_r;
    reg [7:0] vert_normal_thresh_r;
    reg [7:0] horiz_normal_thresh_r;
    reg orient_irq_enable_r;

    // evaluation state
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] code_nxt;
    reg change_r;
    reg [7:0] rdata_nxt;

    wire [1:0] dec_valid;
    wire [1:0] dec_pos;
    wire [1:0] dec_neg;
    wire signed [`SAMPLE_W-1:0] axis_sel [0:1];
    wire [7:0] inplane_sel [0:1];
    wire [7:0] normal_sel [0:1];

    // interrupt plumbing
    wire irq_status;
    wire irq_mask;
    wire irq_line;
    wire irq_clear;
    wire mask_wr;
    wire orient_event;

    // per-direction decisions
    wire is_left;
    wire is_right;
    wire is_down;
    wire is_up;
    wire [2:0] hits;
    wire dec_done;

    assign axis_sel[0] = i_x;
    assign axis_sel[1] = i_y;
    assign inplane_sel[0] = vert_inplane_thresh_r;
    assign inplane_sel[1] = horiz_inplane_thresh_r;
    assign normal_sel[0] = vert_normal_thresh_r;
    assign normal_sel[1] = horiz_normal_thresh_r;

    // index 0 judges up/down on X, index 1 right/left on Y
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_axis
            orient_axis_decide u_decide
            (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_valid(i_sample_valid),
                .i_axis(axis_sel[g]),
                .i_z(i_z),
                .i_inplane_code(inplane_sel[g]),
                .i_normal_code(normal_sel[g]),
                .o_valid(dec_valid[g]),
                .o_pos(dec_pos[g]),
                .o_neg(dec_neg[g])
            );
        end
    endgenerate

    assign is_down = dec_pos[0];
    assign is_up = dec_neg[0];
    assign is_left = dec_pos[1];
    assign is_right = dec_neg[1];
    // more than one direction met is ambiguous
    assign hits = {2'b00, is_left} + {2'b00, is_right} + {2'b00, is_down} + {2'b00, is_up};
    // both axis units register the same sample on the same edge
    assign dec_done = &dec_valid;

    // overlapping portrait and landscape decisions are treated as deadband
    always @*
    begin
        code_nxt = `ORIENT_UNKNOWN;
        if (hits == 3'h1)
        begin
            if (is_left)
            begin
                code_nxt = `ORIENT_LEFT;
            end
            else if (is_right)
            begin
                code_nxt = `ORIENT_RIGHT;
            end
            else if (is_down)
            begin
                code_nxt = `ORIENT_DOWN;
            end
            else
            begin
                code_nxt = `ORIENT_UP;
            end
        end
    end

    // sample sequencing; a new sample may arrive while committing
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
            begin
                if (i_sample_valid)
                begin
                    state_nxt = S_EVAL;
                end
            end
            S_EVAL:
            begin
                if (dec_done)
                begin
                    state_nxt = S_COMMIT;
                end
            end
            S_COMMIT:
            begin
                // a sample one cycle behind is committed straight away, none is lost
                if (dec_done)
                begin
                    state_nxt = S_COMMIT;
                end
                else if (i_sample_valid)
                begin
                    state_nxt = S_EVAL;
                end
                else
                begin
                    state_nxt = S_IDLE;
                end
            end
            default:
            begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= S_IDLE;
            o_orient_code <= `ORIENT_UNKNOWN;
            o_orient_update <= 1'b0;
            change_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            o_orient_update <= 1'b0;
            change_r <= 1'b0;
            // reload on every sample, unknown included, so no stale direction survives
            if ((state_r == S_EVAL || state_r == S_COMMIT) && dec_done)
            begin
                o_orient_code <= code_nxt;
                o_orient_update <= 1'b1;
                change_r <= (code_nxt != o_orient_code);
            end
        end
    end

    // change is a one-cycle pulse; enable gates it here, the mask later
    assign orient_event = change_r & orient_irq_enable_r;
    assign irq_clear = i_wr && hit(i_addr, `REG_IRQ_STATUS) && i_wdata[`IRQ_ORIENT_CHANGE];
    assign mask_wr = i_wr && hit(i_addr, `REG_IRQ_MASK);

    orient_irq_unit u_irq
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_event(orient_event),
        .i_clear(irq_clear),
        .i_mask_wr(mask_wr),
        .i_mask_val(i_wdata[`IRQ_ORIENT_CHANGE]),
        .o_status(irq_status),
        .o_mask(irq_mask),
        .o_irq(irq_line)
    );

    // register writes; paired thresholds are independent, matching them is up to software
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            vert_inplane_thresh_r <= `RST_INPLANE_THRESH;
            horiz_inplane_thresh_r <= `RST_INPLANE_THRESH;
            vert_normal_thresh_r <= `RST_NORMAL_THRESH;
            horiz_normal_thresh_r <= `RST_NORMAL_THRESH;
            orient_irq_enable_r <= 1'b0;
        end
        else if (i_wr)
        begin
            if (hit(i_addr, `REG_VERT_INPLANE_THRESH))
            begin
                vert_inplane_thresh_r <= i_wdata;
            end
            if (hit(i_addr, `REG_HORIZ_INPLANE_THRESH))
            begin
                horiz_inplane_thresh_r <= i_wdata;
            end
            if (hit(i_addr, `REG_VERT_NORMAL_THRESH))
            begin
                vert_normal_thresh_r <= i_wdata;
            end
            if (hit(i_addr, `REG_HORIZ_NORMAL_THRESH))
            begin
                horiz_normal_thresh_r <= i_wdata;
            end
            if (hit(i_addr, `REG_CTRL))
            begin
                orient_irq_enable_r <= i_wdata[`CTRL_ORIENT_IRQ_ENABLE];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always @*
    begin
        rdata_nxt = 8'h00;
        case (i_addr)
            `REG_VERT_INPLANE_THRESH: rdata_nxt = vert_inplane_thresh_r;
            `REG_HORIZ_INPLANE_THRESH: rdata_nxt = horiz_inplane_thresh_r;
            `REG_VERT_NORMAL_THRESH: rdata_nxt = vert_normal_thresh_r;
            `REG_HORIZ_NORMAL_THRESH: rdata_nxt = horiz_normal_thresh_r;
            `REG_CTRL: rdata_nxt = {7'h00, orient_irq_enable_r};
            `REG_ORIENT_STATUS: rdata_nxt = {5'h00, o_orient_code};
            `REG_IRQ_STATUS: rdata_nxt = {7'h00, irq_status};
            `REG_IRQ_MASK: rdata_nxt = {7'h00, irq_mask};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= 8'h00;
            o_irq <= 1'b0;
        end
        else
        begin
            o_rdata <= i_rd ? rdata_nxt : 8'h00;
            o_irq <= irq_line;
        end
    end

endmodule
`default_nettype wire

//--- verif/portrait_landscape_detector_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "orient_map.vh"

module portrait_landscape_detector_monitor
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // sample datapath
    input wire logic i_sample_valid,
    input wire logic signed [`SAMPLE_W-1:0] i_x,
    input wire logic signed [`SAMPLE_W-1:0] i_y,
    input wire logic signed [`SAMPLE_W-1:0] i_z,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // result
    input wire logic [2:0] o_orient_code,
    input wire logic o_orient_update,
    input wire logic o_irq
);
    logic rd_r;
    logic rd_status_r;
    logic mask_r;
    logic mask_old_r;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // mask shadow, delayed once more for the irq output register
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_r <= 1'b0;
            rd_status_r <= 1'b0;
            mask_r <= 1'b0;
            mask_old_r <= 1'b0;
        end
        else
        begin
            rd_r <= i_rd;
            rd_status_r <= i_rd && (i_addr == `REG_ORIENT_STATUS);
            mask_r <= (i_wr && i_addr == `REG_IRQ_MASK) ? i_wdata[0] : mask_r;
            mask_old_r <= mask_r;
        end
    end

    AST_UPDATE_LAT: assert property (i_sample_valid |-> ##2 o_orient_update)
        else $error("no result two cycles after sample");
    AST_UPDATE_CAUSE: assert property (o_orient_update |-> $past(i_sample_valid, 2))
        else $error("result without sample");
    AST_UPDATE_PULSE: assert property (o_orient_update |=> !o_orient_update)
        else $error("update longer than one cycle");
    AST_CODE_HOLD: assert property (!o_orient_update |-> $stable(o_orient_code))
        else $error("code moved without update");
    AST_CODE_LEGAL: assert property (o_orient_code inside {`ORIENT_UNKNOWN, `ORIENT_LEFT,
        `ORIENT_RIGHT, `ORIENT_DOWN, `ORIENT_UP}) else $error("unassigned code");
    AST_STATUS_READ: assert property (rd_status_r && !o_orient_update |-> o_rdata == {5'h00, o_orient_code})
        else $error("status read differs from code");
    AST_RDATA_IDLE: assert property (!rd_r |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_IRQ_MASK: assert property (!mask_r && !mask_old_r |-> !o_irq)
        else $error("irq while masked");
endmodule

bind portrait_landscape_detector portrait_landscape_detector_monitor portrait_landscape_detector_monitor_inst
(
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sample_valid(i_sample_valid),
    .i_x(i_x),
    .i_y(i_y),
    .i_z(i_z),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_orient_code(o_orient_code),
    .o_orient_update(o_orient_update),
    .o_irq(o_irq)
);
`default_nettype wire

//--- verif/sample_source.sv
`timescale 1ns/100ps
`default_nettype none
`include "orient_map.vh"

module sample_source
(
    // clock
    input wire logic i_clk,
    // request from the bench
    input wire logic i_go,
    input wire logic signed [`SAMPLE_W-1:0] i_x,
    input wire logic signed [`SAMPLE_W-1:0] i_y,
    input wire logic signed [`SAMPLE_W-1:0] i_z,
    // sample datapath
    output logic o_valid = 1'b0,
    output logic signed [`SAMPLE_W-1:0] o_x = '0,
    output logic signed [`SAMPLE_W-1:0] o_y = '0,
    output logic signed [`SAMPLE_W-1:0] o_z = '0
);
    // axes of one sample move together; outside valid they toggle so stale data cannot pass
    always @(posedge i_clk)
    begin
        o_valid <= i_go;
        if (i_go)
        begin
            o_x <= i_x;
            o_y <= i_y;
            o_z <= i_z;
        end
        else
        begin
            o_x <= ~o_x;
            o_y <= ~o_y;
            o_z <= ~o_z;
        end
    end
endmodule
`default_nettype wire

//--- verif/portrait_landscape_detector_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "orient_map.vh"

module portrait_landscape_detector_test;
    typedef struct {int ti; int tn; int x; int y; int z; int code;} row_t;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic signed [`SAMPLE_W-1:0] sx = '0;
    logic signed [`SAMPLE_W-1:0] sy = '0;
    logic signed [`SAMPLE_W-1:0] sz = '0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    wire i_sample_valid;
    wire signed [`SAMPLE_W-1:0] i_x;
    wire signed [`SAMPLE_W-1:0] i_y;
    wire signed [`SAMPLE_W-1:0] i_z;
    wire [7:0] o_rdata;
    wire [2:0] o_orient_code;
    wire o_orient_update;
    wire o_irq;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] d;
    // in-plane code, normal code, x, y, z, expected code
    row_t rows[16] = '{
        '{0, 0, -3000, 0, 0, 6},
        '{0, 0, 3000, 0, 0, 5},
        '{0, 0, 0, -3000, 0, 2},
        '{0, 0, 0, 3000, 0, 1},
        '{0, 0, -2949, 0, 0, 0},
        '{0, 0, 2950, 0, -3276, 5},
        '{0, 0, -3000, 0, 3277, 0},
        '{0, 0, -2950, -2000, 0, 6},
        '{0, 0, 3000, -3000, 0, 0},
        '{0, 0, -8192, 0, 0, 6},
        '{255, 0, -1165, 0, 0, 6},
        '{255, 0, 0, 1164, 0, 0},
        '{0, 128, 0, -3000, 1740, 2},
        '{0, 128, 0, 3000, -1741, 0},
        '{0, 127, 3000, 0, -4800, 5},
        '{0, 127, 3000, 0, 4801, 0}
    };

    always #12.5 i_clk = ~i_clk;

    sample_source sample_source_inst
    (
        .i_clk(i_clk),
        .i_go(go),
        .i_x(sx),
        .i_y(sy),
        .i_z(sz),
        .o_valid(i_sample_valid),
        .o_x(i_x),
        .o_y(i_y),
        .o_z(i_z)
    );

    portrait_landscape_detector portrait_landscape_detector_inst
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sample_valid(i_sample_valid),
        .i_x(i_x),
        .i_y(i_y),
        .i_z(i_z),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_orient_code(o_orient_code),
        .o_orient_update(o_orient_update),
        .o_irq(o_irq)
    );

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic prog(input logic [7:0] ti, input logic [7:0] tn);
        wr(`REG_VERT_INPLANE_THRESH, ti);
        wr(`REG_HORIZ_INPLANE_THRESH, ti);
        wr(`REG_VERT_NORMAL_THRESH, tn);
        wr(`REG_HORIZ_NORMAL_THRESH, tn);
    endtask

    // samples stay at least three cycles apart, though the sample path takes one per cycle
    task automatic sample(input int x, input int y, input int z);
        int n;
        n = 0;
        @(posedge i_clk);
        go <= 1'b1;
        sx <= `SAMPLE_W'(x);
        sy <= `SAMPLE_W'(y);
        sz <= `SAMPLE_W'(z);
        @(posedge i_clk);
        go <= 1'b0;
        do
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        while (o_orient_update !== 1'b1 && n < 8);
        chk({7'h00, o_orient_update}, 8'h01);
    endtask

    task automatic irq_chk(input logic e);
        repeat (3) @(posedge i_clk);
        #1;
        chk({7'h00, o_irq}, {7'h00, e});
    endtask

    initial
    begin
        #100000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end

    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[k])
        begin
            prog(8'(rows[k].ti), 8'(rows[k].tn));
            sample(rows[k].x, rows[k].y, rows[k].z);
            chk({5'h00, o_orient_code}, 8'(rows[k].code));
            rd(`REG_ORIENT_STATUS, d);
            chk(d, 8'(rows[k].code));
            $display("row %0d done", k);
        end
        wr(`REG_CTRL, 8'h01);
        wr(`REG_IRQ_MASK, 8'h01);
        sample(-3000, 0, 0);
        @(posedge i_clk);
        i_rst <= 1'b1;
        // hold over several edges so no check straddles the asynchronous clear
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk({5'h00, o_orient_code}, 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        chk(o_rdata, 8'h00);
        // status is read-only, index 8 is unmapped
        wr(`REG_ORIENT_STATUS, 8'hFF);
        for (int k = 0; k < 9; k++)
        begin
            rd(4'(k), d);
            chk(d, 8'h00);
        end
        $display("reset test done");
        wr(`REG_CTRL, 8'h01);
        wr(`REG_IRQ_MASK, 8'h01);
        sample(-3000, 0, 0);
        irq_chk(1'b1);
        rd(`REG_IRQ_STATUS, d);
        chk(d, 8'h01);
        wr(`REG_IRQ_STATUS, 8'h01);
        irq_chk(1'b0);
        sample(-3000, 0, 0);
        rd(`REG_IRQ_STATUS, d);
        chk(d, 8'h00);
        wr(`REG_IRQ_MASK, 8'h00);
        sample(3000, 0, 0);
        irq_chk(1'b0);
        wr(`REG_IRQ_MASK, 8'h01);
        irq_chk(1'b1);
        wr(`REG_IRQ_STATUS, 8'h01);
        wr(`REG_CTRL, 8'h00);
        sample(-3000, 0, 0);
        rd(`REG_IRQ_STATUS, d);
        chk(d, 8'h00);
        $display("irq test done");
        test_done;
    end
endmodule
`default_nettype wire
